// *** hdl/gpio_port.v ***
// six-bit bidirectional general-purpose port with weak pulls and wake
// assumes an apb master on pclk and synchronous pin inputs
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "gpio_port_consts.vh"

//
// Overview of operation
// [R1] six-bit port, each bit usable as input or output except the input-only pin
// [R2] direction bit 1 makes the pin an input, driver released
// [R3] direction bit 0 drives the output latch onto the pin
// [R4] input-only pin never drives; its direction bit reads 1
// [R5] reading port gives pin levels; writing updates the output latch
// [R6] writes are read-modify-write of sampled pins into the latch; the code loads the write data into the latch whole
// [R7] input-only pin reads 0 when reset pin function enabled
// [R8] direction still applies to analog pins; analog pins read 0
// [R9] software keeps direction set for analog pins
// [R10] software sets comparator control before digital use of analog pins
// [R11] an enabled peripheral takes its pin from the port
// [R12] every pin offers change interrupt and weak pull
// [R13] pins except input-only have selectable per-bit pull up or down
// [R14] pulls off for outputs, alternate function, and global disable at reset
// [R15] input-only pin pull-up on in reset-pin mode, off at high voltage
// [R16] low-power wake enable sinks current on the wake pin
// [R17] software charges cap, enables change, sets input, enables wake, sleeps
// [R18] wake pin falling low during sleep raises change and wakes
// [R19] on wake, vector 0004h if interrupts enabled, else next instruction
// [R20] enabled pin differing from last read sets change flag until cleared
module gpio_port #(
    parameter WIDTH = 6
) (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    pin_in,
    pin_out,
    pin_oe,
    pull_up_on,
    pull_down_on,
    wake_sink_on,
    periph_out,
    periph_oe,
    high_voltage_detect,
    change_irq,
    wake_event,
    wake_vector
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire [WIDTH-1:0] pin_in;
    output reg [WIDTH-1:0] pin_out;
    output reg [WIDTH-1:0] pin_oe;
    output reg [WIDTH-1:0] pull_up_on;
    output reg [WIDTH-1:0] pull_down_on;
    output reg wake_sink_on;
    input wire [WIDTH-1:0] periph_out;
    input wire [WIDTH-1:0] periph_oe;
    input wire high_voltage_detect;
    output reg change_irq;
    output reg wake_event;
    output reg [15:0] wake_vector;

    localparam [WIDTH-1:0] IN_ONLY = 1 << `INPUT_ONLY_BIT;

    reg [WIDTH-1:0] latch_r;
    reg [WIDTH-1:0] dir_r;
    reg [WIDTH-1:0] pull_en_r;
    reg [WIDTH-1:0] pull_sel_r;
    reg [WIDTH-1:0] ioc_en_r;
    reg [WIDTH-1:0] analog_r;
    reg [WIDTH-1:0] periph_en_r;
    reg [4:0] ctl_r;
    reg [WIDTH-1:0] last_read_r;
    reg flag_r;
    reg awake_vec_r;
    reg awake_next_r;
    reg [WIDTH-1:0] dir_eff;
    reg [WIDTH-1:0] pin_view;
    reg [WIDTH-1:0] latch_nxt;
    reg [WIDTH-1:0] mismatch;
    reg [31:0] rdata_nxt;
    reg hit;

    wire wr_acc = psel & penable & pwrite & ~pready;
    wire rd_acc = psel & penable & ~pwrite & ~pready;

    // widens a six-bit field onto the data bus
    function [31:0] zext;
        input [WIDTH-1:0] v;
        begin
            zext = 32'h0000_0000;
            zext[WIDTH-1:0] = v;
        end
    endfunction

    // effective direction and digital pin view
    always @* begin
        dir_eff = dir_r | IN_ONLY; // [R4]
        pin_view = pin_in & ~analog_r; // [R8]
        if (ctl_r[`CTL_RESET_PIN_ENABLE]) begin
            pin_view[`INPUT_ONLY_BIT] = 1'b0; // [R7]
        end
        // write data replaces sampled pins whole into latch [R6]
        latch_nxt = pin_view;
        if (wr_acc && paddr == `OFS_PORT_PINS) begin
            latch_nxt = pwdata[WIDTH-1:0];
        end
        mismatch = (pin_view ^ last_read_r) & ioc_en_r; // [R20]
    end

    // read mux and address decode
    always @* begin
        hit = 1'b1;
        case (paddr)
            `OFS_PORT_PINS: rdata_nxt = zext(pin_view); // [R5]
            `OFS_PORT_DIRECTION: rdata_nxt = zext(dir_eff); // [R4]
            `OFS_PULL_ENABLE: rdata_nxt = zext(pull_en_r);
            `OFS_PULL_DIRECTION: rdata_nxt = zext(pull_sel_r);
            `OFS_CHANGE_INT_ENABLE: rdata_nxt = zext(ioc_en_r);
            `OFS_CONTROL: rdata_nxt = {27'h0000000, ctl_r};
            `OFS_STATUS: rdata_nxt = {29'h00000000, awake_next_r, awake_vec_r, flag_r};
            `OFS_ANALOG_SELECT: rdata_nxt = zext(analog_r);
            `OFS_PERIPH_ENABLE: rdata_nxt = zext(periph_en_r);
            default: begin
                rdata_nxt = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
    end

    // apb slave: one wait state, error on unmapped address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (rd_acc) begin
                prdata <= rdata_nxt;
            end
        end
    end

    // configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_r <= {WIDTH{1'b0}};
            dir_r <= `RST_DIRECTION;
            pull_en_r <= {WIDTH{1'b0}};
            pull_sel_r <= {WIDTH{1'b0}};
            ioc_en_r <= {WIDTH{1'b0}};
            analog_r <= {WIDTH{1'b0}};
            periph_en_r <= {WIDTH{1'b0}};
            ctl_r <= `RST_CONTROL; // pulls globally off at reset [R14]
        end else if (wr_acc) begin
            if (paddr == `OFS_PORT_PINS) begin
                latch_r <= latch_nxt; // [R6]
            end
            if (paddr == `OFS_PORT_DIRECTION) begin
                dir_r <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_PULL_ENABLE) begin
                pull_en_r <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_PULL_DIRECTION) begin
                pull_sel_r <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_CHANGE_INT_ENABLE) begin
                ioc_en_r <= pwdata[WIDTH-1:0]; // [R12]
            end
            if (paddr == `OFS_ANALOG_SELECT) begin
                analog_r <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_PERIPH_ENABLE) begin
                periph_en_r <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_CONTROL) begin
                ctl_r <= pwdata[4:0];
            end
        end
    end

    // change detect, sticky flag, sleep wake; set beats clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_read_r <= {WIDTH{1'b0}};
            flag_r <= 1'b0;
            awake_vec_r <= 1'b0;
            awake_next_r <= 1'b0;
            wake_event <= 1'b0;
            wake_vector <= 16'h0000;
        end else begin
            wake_event <= 1'b0;
            if ((rd_acc || wr_acc) && paddr == `OFS_PORT_PINS) begin
                last_read_r <= pin_view; // port access re-arms compare
            end
            if (|mismatch) begin
                flag_r <= 1'b1; // [R20] [R18]
            end else if (wr_acc && paddr == `OFS_STATUS && pwdata[`STS_CHANGE_FLAG]) begin
                flag_r <= 1'b0;
            end
            if (ctl_r[`CTL_SLEEP] && |mismatch) begin
                wake_event <= 1'b1; // [R18]
                if (ctl_r[`CTL_GLOBAL_INTERRUPT_ENABLE]) begin
                    awake_vec_r <= 1'b1; // [R19]
                    wake_vector <= `WAKE_VECTOR;
                end else begin
                    awake_next_r <= 1'b1; // [R19]
                    wake_vector <= 16'h0000;
                end
            end else if (wr_acc && paddr == `OFS_STATUS) begin
                if (pwdata[`STS_AWAKE_VECTOR]) begin
                    awake_vec_r <= 1'b0;
                end
                if (pwdata[`STS_AWAKE_NEXT]) begin
                    awake_next_r <= 1'b0;
                end
            end
        end
    end

    // sleep bit stays set after wake; only the control write or reset changes it
    // pin drivers, pulls and wake sink
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {WIDTH{1'b0}};
            pin_oe <= {WIDTH{1'b0}};
            pull_up_on <= {WIDTH{1'b0}};
            pull_down_on <= {WIDTH{1'b0}};
            wake_sink_on <= 1'b0;
            change_irq <= 1'b0;
        end else begin
            // peripheral owns its pin, else latch drives outputs [R11] [R3] [R2]
            pin_out <= (periph_en_r & periph_out) | (~periph_en_r & latch_r);
            pin_oe <= ((periph_en_r & periph_oe) | (~periph_en_r & ~dir_eff)) & ~IN_ONLY;
            // pulls gated by output, alternate function, global disable [R13] [R14]
            pull_up_on <= pull_en_r & pull_sel_r & dir_eff & ~periph_en_r & ~IN_ONLY
                & {WIDTH{~ctl_r[`CTL_PULL_GLOBAL_DISABLE]}};
            pull_down_on <= pull_en_r & ~pull_sel_r & dir_eff & ~periph_en_r & ~IN_ONLY
                & {WIDTH{~ctl_r[`CTL_PULL_GLOBAL_DISABLE]}};
            // reset-pin pull-up, dropped at high voltage [R15]
            pull_up_on[`INPUT_ONLY_BIT] <= ctl_r[`CTL_RESET_PIN_ENABLE] & ~high_voltage_detect;
            wake_sink_on <= ctl_r[`CTL_LOW_POWER_WAKE_ENABLE]; // [R16]
            change_irq <= flag_r;
        end
    end
endmodule

// *** hdl/gpio_port_consts.vh ***
// register offsets, field positions and reset values of the six-bit port
// assumes inclusion by the port module only
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH
`define OFS_PORT_PINS 12'h000
`define OFS_PORT_DIRECTION 12'h004
`define OFS_PULL_ENABLE 12'h008
`define OFS_PULL_DIRECTION 12'h00C
`define OFS_CHANGE_INT_ENABLE 12'h010
`define OFS_CONTROL 12'h014
`define OFS_STATUS 12'h018
`define OFS_ANALOG_SELECT 12'h01C
`define OFS_PERIPH_ENABLE 12'h020
`define CTL_PULL_GLOBAL_DISABLE 0
`define CTL_LOW_POWER_WAKE_ENABLE 1
`define CTL_GLOBAL_INTERRUPT_ENABLE 2
`define CTL_RESET_PIN_ENABLE 3
`define CTL_SLEEP 4
`define STS_CHANGE_FLAG 0
`define STS_AWAKE_VECTOR 1
`define STS_AWAKE_NEXT 2
`define INPUT_ONLY_BIT 3
`define WAKE_BIT 0
`define RST_DIRECTION 6'h3F
`define RST_CONTROL 5'h01
`define WAKE_VECTOR 16'h0004
`endif

// *** verification/gpio_port_asserts.sv ***
// checker on the port's pin enables, pulls, bus answer and wake outputs
// assumes a bind to every gpio_port instance
`timescale 1ns/10ps
module gpio_port_asserts #(
    parameter WIDTH = 6
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire [WIDTH-1:0] pin_oe,
    input wire [WIDTH-1:0] pull_up_on,
    input wire [WIDTH-1:0] pull_down_on,
    input wire high_voltage_detect,
    input wire wake_event,
    input wire [15:0] wake_vector
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pin and pull relations
    oe_input_only_a: assert property (!pin_oe[3]) else $error("pin 3 driven");
    pull_out_off_a: assert property (((pull_up_on | pull_down_on) & pin_oe) == 0)
        else $error("pull on an output");
    pull_excl_a: assert property ((pull_up_on & pull_down_on) == 0)
        else $error("both pulls on");
    pull3_down_a: assert property (!pull_down_on[3]) else $error("pin 3 pulled down");
    hv_pull_off_a: assert property (high_voltage_detect [*2] |-> !pull_up_on[3])
        else $error("pin 3 pull-up at high voltage");
    // bus answer after one wait state, one cycle long
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("late bus answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
    wake_vec_a: assert property (wake_event |-> (wake_vector & 16'hFFFB) == 0)
        else $error("bad wake vector");
endmodule
bind gpio_port gpio_port_asserts #(.WIDTH(WIDTH)) i_chk (.*);

// *** verification/pin_model.sv ***
// outside drivers and weak pulls on the six pins, and a wake capacitor on pin 0
// assumes pin_lvl feeds the port's pin inputs
`timescale 1ns/10ps
module pin_model (
    input wire pclk,
    input wire [5:0] pin_out,
    input wire [5:0] pin_oe,
    input wire [5:0] pull_up_on,
    input wire [5:0] pull_down_on,
    input wire wake_sink_on,
    input wire [5:0] ext_val,
    input wire [5:0] ext_en,
    output logic [5:0] pin_lvl
);
    logic cap = 1'b0;
    logic flt = 1'b0;
    logic [3:0] dis = 4'h0;
    // capacitor charges while driven high and drains through the sink
    always @(posedge pclk) begin
        flt <= !flt;
        if (pin_oe[0] && pin_out[0]) begin
            cap <= 1'b1;
            dis <= 4'h0;
        end else if (wake_sink_on) begin
            dis <= dis + 4'h1;
            if (dis == 4'hF) cap <= 1'b0;
        end
    end
    // a floating pin toggles so stale levels never pass
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pull_up_on[i] || (i == 0 && cap)) pin_lvl[i] = 1'b1;
            else if (pull_down_on[i]) pin_lvl[i] = 1'b0;
            else if (i == 0 && wake_sink_on) pin_lvl[i] = 1'b0;
            else pin_lvl[i] = flt;
        end
    end
endmodule

// *** verification/tb.sv ***
// bench for the six-bit port: registers, pins, pulls and wake
// assumes gpio_port and pin_model compiled alongside
`timescale 1ns/10ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic high_voltage_detect = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, change_irq, wake_event, wake_sink_on;
    logic [5:0] pin_in, pin_out, pin_oe, pull_up_on, pull_down_on;
    logic [5:0] periph_out = 6'h00, periph_oe = 6'h00, ext_val = 6'h00, ext_en = 6'h3F;
    logic [15:0] wake_vector;
    int miscompares = 0;
    int total_checks = 0;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_t;
    row_t rows [5] = '{'{12'h004, 32'h0, 32'h8, 1'b0}, '{12'h004, 32'h3F, 32'h3F, 1'b0},
        '{12'h00C, 32'h15, 32'h15, 1'b0}, '{12'h010, 32'h2A, 32'h2A, 1'b0},
        '{12'h040, 32'h3F, 32'h0, 1'b1}};
    gpio_port #(.WIDTH(6)) i_dut (.*);
    pin_model i_pins (.*, .pin_lvl(pin_in));
    always #5 pclk = ~pclk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hang(input logic s);
        if (s !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask
    // one bus transfer: setup, access, wait for the answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        hang(pready);
    endtask
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 200 && s !== 1'b1; n++) @(posedge pclk);
        hang(s);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
            chk({31'h0, er}, {31'h0, rows[i].err});
        end
        $display("register rows done");
        // the latch drives the outputs, input-only pin stays released
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h2A);
        @(posedge pclk);
        chk(pin_oe, 6'h37);
        chk(pin_out & pin_oe, 6'h22);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h22);
        ext_val <= 6'h09;
        apb(1'b1, 12'h014, 32'h08);
        @(posedge pclk);
        chk(pull_up_on[3], 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd[3], 1'b0);
        high_voltage_detect <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(pull_up_on[3], 1'b0);
        high_voltage_detect <= 1'b0;
        apb(1'b1, 12'h004, 32'h3F);
        apb(1'b1, 12'h01C, 32'h01);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h01C, 32'h0);
        $display("pin tests done");
        // pulls follow select, drop on outputs and global disable
        apb(1'b1, 12'h014, 32'h0);
        ext_en <= 6'h00;
        apb(1'b1, 12'h008, 32'h3F);
        apb(1'b1, 12'h00C, 32'h15);
        @(posedge pclk);
        chk({pull_up_on, pull_down_on}, {6'h15, 6'h22});
        apb(1'b1, 12'h004, 32'h0F);
        @(posedge pclk);
        chk({pull_up_on, pull_down_on}, {6'h05, 6'h02});
        periph_oe <= 6'h02;
        periph_out <= 6'h02;
        apb(1'b1, 12'h020, 32'h02);
        @(posedge pclk);
        chk(pin_oe[1] & pin_out[1], 1'b1);
        apb(1'b1, 12'h020, 32'h0);
        apb(1'b1, 12'h014, 32'h01);
        @(posedge pclk);
        chk({pull_up_on, pull_down_on}, 12'h000);
        $display("pull tests done");
        // change on an enabled pin raises the flag until cleared
        ext_en <= 6'h3F;
        ext_val <= 6'h00;
        apb(1'b1, 12'h004, 32'h3F);
        apb(1'b1, 12'h010, 32'h04);
        apb(1'b0, 12'h000, 32'h0);
        ext_val <= 6'h04;
        wait_hi(change_irq);
        apb(1'b0, 12'h000, 32'h0);
        apb(1'b1, 12'h018, 32'h01);
        @(posedge pclk);
        chk(change_irq, 1'b0);
        // charge, release, sink and sleep until the pin drains
        ext_en <= 6'h3E;
        apb(1'b1, 12'h004, 32'h3E);
        apb(1'b1, 12'h000, 32'h01);
        apb(1'b1, 12'h010, 32'h01);
        apb(1'b1, 12'h004, 32'h3F);
        apb(1'b0, 12'h000, 32'h0);
        apb(1'b1, 12'h014, 32'h17);
        @(posedge pclk);
        chk(wake_sink_on, 1'b1);
        wait_hi(wake_event);
        chk(wake_vector, 32'h0004);
        $display("wake test done");
        // second reset restores direction and control
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h3F);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h01);
        $display("reset test done");
        give_verdict();
    end
endmodule
